// file: fbm_pkg.sv
// Shared constants for the flash bus-mode and status-polling controller.
// Assumes a 40 MHz sys_clk and a byte-wide asynchronous flash on the pins.
package fbm_pkg;

  // Clock period and pin timing, in ns
  localparam int CLK_NS = 25;
  localparam int T_SETUP_NS = 25;
  localparam int T_ACC_NS = 200;
  localparam int T_WP_NS = 50;
  localparam int T_HOLD_NS = 25;
  localparam int T_VID_NS = 1000;

  // Least times round up to whole cycles, never below one
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int VID_CYC = (T_VID_NS + CLK_NS - 1) / CLK_NS;

  // Poll pair limit before the controller gives up
  localparam int POLL_LIMIT_DEF = 1000000;

  // Widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int AVS_AW = 5;

  // Register byte offsets
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_ADDR = 5'h04;
  localparam logic [4:0] OFF_WDATA = 5'h08;
  localparam logic [4:0] OFF_RDATA = 5'h0C;
  localparam logic [4:0] OFF_STATUS = 5'h10;

  // Command codes in the command register
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_POLL = 3'h3;
  localparam logic [2:0] OP_IDCODE = 3'h4;
  localparam logic [2:0] OP_PROTECT = 3'h5;

  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_WINDOW = 3;
  localparam int ST_MATCH = 4;

  // Status bits on the flash data pins
  localparam int POLLING_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int TIMEOUT_FAILURE_BIT = 5;
  localparam int ERASE_WINDOW_BIT = 3;

  // Address lines forced for identification reads
  localparam int ADDRESS_BIT_ZERO = 0;
  localparam int ADDRESS_BIT_ONE = 1;
  localparam int ADDRESS_BIT_SIX = 6;

  // Top-level sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    FBM_IDLE = 3'h0,
    FBM_VID = 3'h1,
    FBM_RUN = 3'h3,
    FBM_POLL1 = 3'h2,
    FBM_POLL2 = 3'h6,
    FBM_FINAL = 3'h7
  } fbm_state_t;

  // Pin cycle states
  typedef enum logic [1:0] {
    FBM_C_IDLE = 2'h0,
    FBM_C_SETUP = 2'h1,
    FBM_C_STROBE = 2'h3,
    FBM_C_HOLD = 2'h2
  } fbm_cyc_state_t;

endpackage : fbm_pkg

// file: fbm_cycle.sv
// One read or write bus cycle on the flash pins.
// Assumes start is a one-cycle pulse given only while done is not pending.
`timescale 1ns/1ps
module fbm_cycle
  import fbm_pkg::*;
#(
  parameter int P_SETUP = SETUP_CYC,
  parameter int P_ACC = ACC_CYC,
  parameter int P_WP = WP_CYC,
  parameter int P_HOLD = HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_cs_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe
);

  typedef struct packed {
    fbm_cyc_state_t st;
    logic [7:0] cnt;
    logic wr;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } fbm_cyc_t;

  fbm_cyc_t cur;
  fbm_cyc_t next_cur;

  // Strobe sequencing: setup, strobe, hold
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      FBM_C_IDLE: begin
        if (start) begin
          next_cur.st = FBM_C_SETUP;
          next_cur.cnt = 8'h00;
          next_cur.wr = is_write;
          next_cur.addr = addr_in;
          next_cur.cs_n = 1'b0;
          next_cur.oe_n = 1'b1;
          next_cur.dq_out = wdata;
          next_cur.dq_oe = is_write;
        end
      end
      FBM_C_SETUP: begin
        next_cur.cnt = cur.cnt + 8'h01;
        if (cur.cnt == 8'(P_SETUP - 1)) begin
          next_cur.st = FBM_C_STROBE;
          next_cur.cnt = 8'h00;
          next_cur.we_n = ~cur.wr;
          next_cur.oe_n = cur.wr;
        end
      end
      FBM_C_STROBE: begin
        next_cur.cnt = cur.cnt + 8'h01;
        if (cur.wr && cur.cnt == 8'(P_WP - 1)) begin
          next_cur.st = FBM_C_HOLD;
          next_cur.cnt = 8'h00;
          next_cur.we_n = 1'b1;
        end else if (!cur.wr && cur.cnt == 8'(P_ACC - 1)) begin
          next_cur.st = FBM_C_HOLD;
          next_cur.cnt = 8'h00;
          next_cur.rdata = flash_dq_in;
          next_cur.oe_n = 1'b1;
        end
      end
      FBM_C_HOLD: begin
        next_cur.cnt = cur.cnt + 8'h01;
        if (cur.cnt == 8'(P_HOLD - 1)) begin
          next_cur.st = FBM_C_IDLE;
          next_cur.cs_n = 1'b1;
          next_cur.dq_oe = 1'b0;
          next_cur.done = 1'b1;
        end
      end
      default: begin
        next_cur.st = FBM_C_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur <= '{st: FBM_C_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0,
               rdata: '0, addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
               dq_out: '0, dq_oe: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  assign done = cur.done;
  assign rdata = cur.rdata;
  assign flash_addr = cur.addr;
  assign flash_cs_n = cur.cs_n;
  assign flash_oe_n = cur.oe_n;
  assign flash_we_n = cur.we_n;
  assign flash_dq_out = cur.dq_out;
  assign flash_dq_oe = cur.dq_oe;

endmodule : fbm_cycle

// file: fbm_ctrl.sv
// Host controller for a byte-wide flash: raw bus cycles, identification
// reads and status polling, ordered by software over Avalon-MM.
// Assumes a high-voltage switch on the identification address line that
// follows flash_vid_en, and pin inputs synchronous to sys_clk.
// Behaviour
// - Host polls at an unprotected address inside a sector being erased.
// - After polling shows true data, read again before trusting other bits.
// - After erase failure host issues reset sequence before new operations; the controller only sets the fail bit and leaves that to software.
// - Host reads erase window bit around each added sector command; the controller latches it only on status polls.
// - Host write: chip select and write strobe low, output enable high.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module fbm_ctrl
  import fbm_pkg::*;
#(
  parameter int POLL_LIMIT = POLL_LIMIT_DEF,
  parameter int P_VID = VID_CYC,
  parameter int P_ACC = ACC_CYC,
  parameter int P_WP = WP_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_cs_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_vid_en
);

  typedef struct packed {
    fbm_state_t st;
    logic waitreq;
    logic [31:0] bus_rdata;
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] first;
    logic [ADDR_W-1:0] cyc_addr;
    logic cyc_wr;
    logic start;
    logic busy;
    logic done;
    logic fail;
    logic window;
    logic match;
    logic retry;
    logic vid_en;
    logic [31:0] count;
  } fbm_ctrl_t;

  fbm_ctrl_t cur;
  fbm_ctrl_t next_cur;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [ADDR_W-1:0] id_addr;
  logic [31:0] status_word;

  // Identification address: bit six low, bit one high, bit zero selects
  always_comb begin
    id_addr = cur.addr;
    id_addr[ADDRESS_BIT_SIX] = 1'b0;
    id_addr[ADDRESS_BIT_ONE] = 1'b1;
    id_addr[ADDRESS_BIT_ZERO] = (avs_writedata[2:0] == OP_IDCODE);
  end

  // Status register image
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_BUSY] = cur.busy;
    status_word[ST_DONE] = cur.done;
    status_word[ST_FAIL] = cur.fail;
    status_word[ST_WINDOW] = cur.window;
    status_word[ST_MATCH] = cur.match;
  end

  // Sequencer and register file
  always_comb begin
    next_cur = cur;
    next_cur.start = 1'b0;
    next_cur.waitreq = 1'b1;
    case (cur.st)
      FBM_IDLE: begin
        next_cur.vid_en = 1'b0;
      end
      FBM_VID: begin
        // Let the high voltage settle before the code read
        next_cur.count = cur.count + 32'h0000_0001;
        if (cur.count == 32'(P_VID - 1)) begin
          next_cur.start = 1'b1;
          next_cur.st = FBM_RUN;
        end
      end
      FBM_RUN: begin
        if (cyc_done) begin
          if (!cur.cyc_wr) begin
            next_cur.rdata = cyc_rdata;
          end
          next_cur.vid_en = 1'b0;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
          next_cur.st = FBM_IDLE;
        end
      end
      FBM_POLL1: begin
        if (cyc_done) begin
          next_cur.first = cyc_rdata;
          next_cur.start = 1'b1;
          next_cur.st = FBM_POLL2;
        end
      end
      FBM_POLL2: begin
        if (cyc_done) begin
          next_cur.rdata = cyc_rdata;
          next_cur.window = cyc_rdata[ERASE_WINDOW_BIT];
          next_cur.count = cur.count + 32'h0000_0001;
          if (cyc_rdata[TOGGLE_STATUS_BIT] ==
              cur.first[TOGGLE_STATUS_BIT]) begin
            // Toggling stopped: one more read for trusted data
            next_cur.start = 1'b1;
            next_cur.st = FBM_FINAL;
          end else if (cyc_rdata[TIMEOUT_FAILURE_BIT] && cur.retry) begin
            // Still toggling after the failure bit: give up and leave the
            // reset command sequence to software before new work
            next_cur.fail = 1'b1;
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
            next_cur.st = FBM_IDLE;
          end else if (cur.count == 32'(POLL_LIMIT - 1)) begin
            next_cur.fail = 1'b1;
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
            next_cur.st = FBM_IDLE;
          end else begin
            // Failure bit may race completion: check one more pair
            next_cur.retry = cyc_rdata[TIMEOUT_FAILURE_BIT];
            next_cur.start = 1'b1;
            next_cur.st = FBM_POLL1;
          end
        end
      end
      FBM_FINAL: begin
        if (cyc_done) begin
          next_cur.rdata = cyc_rdata;
          next_cur.window = cyc_rdata[ERASE_WINDOW_BIT];
          next_cur.match = (cyc_rdata[POLLING_STATUS_BIT] ==
                            cur.wdata[POLLING_STATUS_BIT]);
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
          next_cur.st = FBM_IDLE;
        end
      end
      default: begin
        next_cur.st = FBM_IDLE;
      end
    endcase

    // Avalon slave: accept once, waitrequest low for one cycle
    if ((avs_read || avs_write) && cur.waitreq) begin
      next_cur.waitreq = 1'b0;
      if (avs_read) begin
        case (avs_address)
          OFF_CMD: next_cur.bus_rdata = {29'h000_0000, cur.op};
          OFF_ADDR: next_cur.bus_rdata = {13'h0000, cur.addr};
          OFF_WDATA: next_cur.bus_rdata = {24'h00_0000, cur.wdata};
          OFF_RDATA: next_cur.bus_rdata = {24'h00_0000, cur.rdata};
          OFF_STATUS: next_cur.bus_rdata = status_word;
          default: next_cur.bus_rdata = 32'h0000_0000;
        endcase
      end else begin
        case (avs_address)
          OFF_ADDR: begin
            next_cur.addr = avs_writedata[ADDR_W-1:0];
          end
          OFF_WDATA: begin
            next_cur.wdata = avs_writedata[DATA_W-1:0];
          end
          OFF_CMD: begin
            // New operations are taken only while idle
            if (cur.st == FBM_IDLE) begin
              next_cur.op = avs_writedata[2:0];
              next_cur.busy = 1'b1;
              next_cur.done = 1'b0;
              next_cur.fail = 1'b0;
              next_cur.match = 1'b0;
              next_cur.retry = 1'b0;
              next_cur.count = 32'h0000_0000;
              next_cur.cyc_addr = cur.addr;
              next_cur.cyc_wr = 1'b0;
              case (avs_writedata[2:0])
                OP_READ: begin
                  next_cur.start = 1'b1;
                  next_cur.st = FBM_RUN;
                end
                OP_WRITE: begin
                  next_cur.cyc_wr = 1'b1;
                  next_cur.start = 1'b1;
                  next_cur.st = FBM_RUN;
                end
                OP_POLL: begin
                  next_cur.start = 1'b1;
                  next_cur.st = FBM_POLL1;
                end
                OP_IDCODE, OP_PROTECT: begin
                  next_cur.cyc_addr = id_addr;
                  next_cur.vid_en = 1'b1;
                  next_cur.st = FBM_VID;
                end
                default: begin
                  next_cur.busy = 1'b0;
                  next_cur.done = 1'b1;
                end
              endcase
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur <= '{st: FBM_IDLE, waitreq: 1'b1, bus_rdata: 32'h0000_0000,
               op: OP_NONE, addr: '0, wdata: '0, rdata: '0, first: '0,
               cyc_addr: '0, cyc_wr: 1'b0, start: 1'b0, busy: 1'b0,
               done: 1'b0, fail: 1'b0, window: 1'b0, match: 1'b0,
               retry: 1'b0, vid_en: 1'b0, count: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  // Pin cycle engine
  fbm_cycle #(
    .P_SETUP(SETUP_CYC),
    .P_ACC(P_ACC),
    .P_WP(P_WP),
    .P_HOLD(HOLD_CYC)
  ) u_cycle (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(cur.start),
    .is_write(cur.cyc_wr),
    .addr_in(cur.cyc_addr),
    .wdata(cur.wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_cs_n(flash_cs_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe)
  );

  // Outputs from registers
  assign avs_readdata = cur.bus_rdata;
  assign avs_waitrequest = cur.waitreq;
  assign flash_vid_en = cur.vid_en;

endmodule : fbm_ctrl

// file: fbm_flash_model.sv
// Behavioural byte-wide flash facing the controller's pins.
// Assumes the bench picks which embedded operation a bus write starts.
`timescale 1ns/1ps
module fbm_flash_model
  import fbm_pkg::*;
#(
  parameter logic [7:0] CODE_UNPROT = 8'h5A, // Arbitrary value
  parameter logic [7:0] CODE_PROT = 8'h01 // Arbitrary value
) (
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_cs_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_vid_en,
  input wire logic [1:0] op_mode,
  input wire logic [7:0] busy_len,
  output logic [DATA_W-1:0] flash_dq_in
);
  logic [7:0] mem [0:255];
  logic [7:0] last_wr = 8'h00;
  logic [7:0] held = 8'h00;
  logic [7:0] nrd = 8'h00;
  logic [7:0] ea = 8'h00;
  logic [7:0] ea2 = 8'h00;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic [7:0] val;
  logic [1:0] busy = 2'd0; // Wakes in read mode
  logic tog = 1'b0;

  // Blank array at power-up
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  end

  // A write ends on the write strobe's rise, ignored while an operation
  // runs except an added erase sector before the first read; a read ends on
  // output enable's rise and, while busy, flips the toggle bit and counts up.
  // One process, so each variable but mem (also set at power-up) has one driver
  always @(flash_we_n or flash_oe_n) begin
    if (flash_we_n && !we_q && !flash_cs_n && flash_oe_n) begin
      if (busy == 2'd0) begin
        mem[flash_addr[7:0]] <= flash_dq_out;
        last_wr <= flash_dq_out;
        ea <= flash_addr[7:0];
        ea2 <= flash_addr[7:0];
        busy <= op_mode;
        nrd <= 8'h00;
      end else if (busy == 2'd2 && nrd == 8'h00) begin
        // Window still open: a further sector joins the erase
        ea2 <= flash_addr[7:0];
      end
    end
    if (flash_oe_n && !oe_q && !flash_cs_n) begin
      held <= val;
      if (busy != 2'd0) begin
        tog <= ~tog;
        nrd <= nrd + 8'h01;
        if (busy != 2'd3 && nrd + 8'h01 >= busy_len) begin
          busy <= 2'd0;
          if (busy == 2'd2) begin
            mem[ea] <= 8'hFF;
            mem[ea2] <= 8'hFF;
          end
        end
      end
    end
    we_q = flash_we_n;
    oe_q = flash_oe_n;
  end

  // Byte presented on a read: code, status or array data
  always @* begin
    val = mem[flash_addr[7:0]];
    if (flash_vid_en && !flash_addr[ADDRESS_BIT_SIX] &&
        flash_addr[ADDRESS_BIT_ONE]) begin
      val = flash_addr[ADDRESS_BIT_ZERO] ? CODE_UNPROT : CODE_PROT;
    end else if (busy != 2'd0) begin
      val = last_wr;
      val[POLLING_STATUS_BIT] = (busy != 2'd2) & ~last_wr[7];
      val[TOGGLE_STATUS_BIT] = tog;
      val[TIMEOUT_FAILURE_BIT] = busy == 2'd3 && nrd != 8'h00;
      val[ERASE_WINDOW_BIT] = busy == 2'd2 && nrd != 8'h00;
    end
  end

  // Wire level: controller, then flash on a read, else a changed level
  assign flash_dq_in = flash_dq_oe ? flash_dq_out
    : (!flash_cs_n && !flash_oe_n && flash_we_n) ? val : ~held;
endmodule : fbm_flash_model

// file: fbm_ctrl_properties.sv
// Checker on the controller's ports, bound into every fbm_ctrl.
// Assumes default cycle timings (access 8, write pulse 2, hold 1).
`timescale 1ns/1ps
module fbm_ctrl_properties
  import fbm_pkg::*;
#(
  parameter int P_VID = VID_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_cs_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_dq_oe,
  input wire logic flash_vid_en
);
  logic [7:0] vid_cnt;

  // Cycles spent with the identification voltage applied
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vid_cnt <= 8'h00;
    end else if (!flash_vid_en) begin
      vid_cnt <= 8'h00;
    end else if (vid_cnt != 8'hFF) begin
      vid_cnt <= vid_cnt + 8'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("No answer to a request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low too long");
  a_wait_cause: assert property ($fell(avs_waitrequest)
    |-> $past(avs_read) || $past(avs_write)) else $error("Unasked answer");
  a_read_strobes: assert property (!flash_oe_n |->
    !flash_cs_n && flash_we_n && !flash_dq_oe) else $error("Bad read pins");
  a_write_strobes: assert property (!flash_we_n |->
    !flash_cs_n && flash_oe_n && flash_dq_oe) else $error("Bad write pins");
  a_read_width: assert property ($fell(flash_oe_n) |->
    !flash_oe_n [*8] ##1 flash_oe_n) else $error("Read strobe width");
  a_write_end: assert property ($rose(flash_we_n) |->
    !flash_cs_n && flash_dq_oe ##1 flash_cs_n && !flash_dq_oe)
    else $error("Write release order");
  a_id_lines: assert property (flash_vid_en && !flash_oe_n |->
    !flash_addr[ADDRESS_BIT_SIX] && flash_addr[ADDRESS_BIT_ONE])
    else $error("Id read address lines");
  a_id_settle: assert property (flash_vid_en && $fell(flash_oe_n) |->
    vid_cnt >= P_VID) else $error("Id voltage not settled");
  a_vid_release: assert property ($fell(flash_vid_en) |-> flash_cs_n)
    else $error("Id voltage dropped mid cycle");

  c_write: cover property ($rose(flash_we_n));
  c_id_read: cover property (flash_vid_en && $fell(flash_oe_n));
  c_plain_read: cover property (!flash_vid_en && $fell(flash_oe_n));
endmodule : fbm_ctrl_properties

bind fbm_ctrl fbm_ctrl_properties #(.P_VID(P_VID)) u_props (
  .sys_clk(sys_clk), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .flash_addr(flash_addr), .flash_cs_n(flash_cs_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_dq_oe(flash_dq_oe), .flash_vid_en(flash_vid_en)
);

// file: fbm_ctrl_bench.sv
// Self-checking bench: Avalon tasks drive the controller against the flash.
// Assumes the flash model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module fbm_ctrl_bench import fbm_pkg::*; ;
  localparam logic [7:0] CODE_UNPROT = 8'h5A; // Arbitrary value
  localparam logic [7:0] CODE_PROT = 8'h01; // Arbitrary value
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [AVS_AW-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, r1;
  logic [ADDR_W-1:0] flash_addr;
  logic flash_cs_n, flash_oe_n, flash_we_n, flash_dq_oe, flash_vid_en;
  logic [DATA_W-1:0] flash_dq_in, flash_dq_out;
  logic [1:0] op_mode;
  logic [7:0] busy_len;
  int error_cnt, n_checks;

  fbm_ctrl #(.POLL_LIMIT(4), .P_VID(2)) uut (.sys_clk(sys_clk),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_addr(flash_addr), .flash_cs_n(flash_cs_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_vid_en(flash_vid_en));
  fbm_flash_model #(.CODE_UNPROT(CODE_UNPROT), .CODE_PROT(CODE_PROT))
    flash (.flash_addr(flash_addr), .flash_cs_n(flash_cs_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_vid_en(flash_vid_en), .op_mode(op_mode),
    .busy_len(busy_len), .flash_dq_in(flash_dq_in));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic tmo;
    error_cnt++;
    $display("Error at %0t: wait ran out", $time);
    close_out();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) tmo();
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : av

  // Start a controller command and wait until it is no longer busy
  task automatic run_op(input logic [2:0] code, input logic [18:0] a);
    int n;
    n = 0;
    av(1'b1, OFF_ADDR, {13'h0, a});
    av(1'b1, OFF_CMD, {29'h0, code});
    rd = 32'h1;
    while (rd[ST_BUSY] !== 1'b0) begin
      n++;
      if (n > 300) tmo();
      av(1'b0, OFF_STATUS, 32'h0);
    end
  endtask : run_op

  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    op_mode = 2'd0;
    busy_len = 8'h04;
    error_cnt = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk({27'h0, flash_cs_n, flash_oe_n, flash_we_n, flash_dq_oe,
         flash_vid_en}, 32'h1C);
    av(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    av(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    $display("test idle done");
    // Plain program and read back of one byte
    av(1'b1, OFF_WDATA, 32'hA5);
    run_op(OP_WRITE, 19'h12);
    run_op(OP_READ, 19'h12);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'hA5);
    $display("test read write done");
    // Both identification reads
    run_op(OP_IDCODE, 19'h0);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, {24'h0, CODE_UNPROT});
    run_op(OP_PROTECT, 19'h0);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, {24'h0, CODE_PROT});
    run_op(3'h7, 19'h0);
    av(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h2);
    av(1'b0, OFF_CMD, 32'h0);
    chk(rd, 32'h7);
    $display("test id done");
    // Embedded program: status while busy, then poll to the true byte
    op_mode <= 2'd1;
    av(1'b1, OFF_WDATA, 32'h3C);
    run_op(OP_WRITE, 19'h20);
    run_op(OP_READ, 19'h20);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'h94);
    run_op(OP_POLL, 19'h20);
    chk(rd, 32'h1A);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'h3C);
    $display("test program done");
    // Embedded erase with an added sector: polling bit low, window closes
    op_mode <= 2'd2;
    run_op(OP_WRITE, 19'h20);
    run_op(OP_WRITE, 19'h12);
    run_op(OP_READ, 19'h20);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd & 32'h88, 32'h0);
    r1 = rd;
    run_op(OP_READ, 19'h20);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd & 32'h88, 32'h08);
    chk({31'h0, rd[6] ^ r1[6]}, 32'h1);
    av(1'b1, OFF_WDATA, 32'hFF);
    run_op(OP_POLL, 19'h20);
    chk(rd, 32'h1A);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'hFF);
    run_op(OP_READ, 19'h12);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'hFF);
    $display("test erase done");
    // Program that outlasts the poll limit, then finishes
    op_mode <= 2'd1;
    busy_len <= 8'h40;
    av(1'b1, OFF_WDATA, 32'h55);
    run_op(OP_WRITE, 19'h40);
    run_op(OP_POLL, 19'h40);
    chk(rd, 32'h6);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'hD5);
    busy_len <= 8'h01;
    run_op(OP_POLL, 19'h40);
    chk(rd, 32'h12);
    av(1'b0, OFF_RDATA, 32'h0);
    chk(rd, 32'h55);
    $display("test poll limit done");
    // Locked program on a blank byte ends in failure
    op_mode <= 2'd3;
    run_op(OP_WRITE, 19'h30);
    run_op(OP_POLL, 19'h30);
    chk({31'h0, rd[ST_FAIL]}, 32'h1);
    $display("test failure done");
    close_out();
  end
endmodule : fbm_ctrl_bench
